//--- verilog/host_port_select_and_rx_ctrl.sv
/*
 * Parallel host port with expansion select decoder, hardware reset filter
 * and receiver power and termination control for fourteen channels.
 * Assumes all pins asynchronous to clk_sys; address low bits and data
 * are stable while a strobe is held.
 */
`timescale 1ns/100ps

module host_port_select_and_rx_ctrl
    import host_port_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        host_reset_n,
    input  wire logic [2:0]  host_type_select,
    input  wire logic        host_cs_n,
    input  wire logic        host_ale_ts,
    input  wire logic        host_wr_rw,
    input  wire logic        host_rd_we,
    input  wire logic        host_bus_clk,
    input  wire logic [10:0] host_addr,
    input  wire logic [7:0]  host_data_in,
    output logic      [7:0]  host_data_out,
    output logic             host_data_oe,
    output logic             host_ready,
    output logic             local_select,
    output logic             expansion_select_out_1,
    output logic             expansion_select_out_2,
    output logic             expansion_select_out_3,
    output logic             expansion_select_out_4,
    output logic             expansion_select_out_5,
    input  wire logic        receiver_power_gate,
    input  wire logic        receive_termination_pin,
    output logic [13:0]      receiver_on,
    output logic [13:0]      termination_on
);

    localparam logic [`HP_SYNC_W-1:0] SYNC_IDLE  = `HP_SYNC_IDLE;
    localparam logic [10:0]           RST_CYC_M1 = 11'(`HP_RESET_CYCLES - 1);

    // -------------------------------------------------------------------------
    // Decoders
    // -------------------------------------------------------------------------
    function automatic logic [5:0] select_decode(input logic [2:0] hi);
        logic [5:0] s;
        s = 6'h00;
        unique case (hi)
            3'h0: s = 6'h01;
            3'h1: s = 6'h02;
            3'h2: s = 6'h04;
            3'h3: s = 6'h08;
            3'h4: s = 6'h10;
            3'h5: s = 6'h20;
            3'h6: s = 6'h00;
            3'h7: s = 6'h3f;
        endcase
        return s;
    endfunction

    // -------------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------------
    logic [`HP_SYNC_W-1:0] pin_in;
    logic [`HP_SYNC_W-1:0] s1_r;
    logic [`HP_SYNC_W-1:0] s2_r;
    logic [`HP_SYNC_W-1:0] s3_r;
    logic [`HP_SYNC_W-1:0] q_r;

    assign pin_in = {host_addr[10:8], host_type_select, receive_termination_pin, receiver_power_gate,
                     host_reset_n, host_bus_clk, host_rd_we, host_wr_rw, host_ale_ts, host_cs_n};

    genvar gi;
    generate
        for (gi = 0; gi < `HP_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    s1_r[gi] <= SYNC_IDLE[gi];
                    s2_r[gi] <= SYNC_IDLE[gi];
                    s3_r[gi] <= SYNC_IDLE[gi];
                    q_r[gi]  <= SYNC_IDLE[gi];
                end else begin
                    s1_r[gi] <= pin_in[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        q_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate

    logic       cs_q;
    logic       gate_q;
    logic       tpin_q;
    logic [2:0] addr_hi_q;
    logic [2:0] type_q;
    logic       hclk_prev_r;

    assign cs_q      = !q_r[`HP_SY_CS_N];
    assign gate_q    = q_r[`HP_SY_GATE];
    assign tpin_q    = q_r[`HP_SY_TPIN];
    assign type_q    = q_r[`HP_SY_TYPE_LSB +: 3];
    assign addr_hi_q = q_r[`HP_SY_ADDR_LSB +: 3];

    // -------------------------------------------------------------------------
    // Hardware reset filter
    // -------------------------------------------------------------------------
    logic [10:0] hrst_cnt_r;
    logic        hw_reset_fire;

    assign hw_reset_fire = !q_r[`HP_SY_HRST_N] && (hrst_cnt_r == RST_CYC_M1);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hrst_cnt_r <= 11'h000;
        end else if (q_r[`HP_SY_HRST_N]) begin
            hrst_cnt_r <= 11'h000;
        end else if (hrst_cnt_r != RST_CYC_M1 + 11'h001) begin
            hrst_cnt_r <= hrst_cnt_r + 11'h001;
        end
    end

    // -------------------------------------------------------------------------
    // Bus style strobes and access state
    // -------------------------------------------------------------------------
    acc_state_t state_r;
    logic       rd_lvl;
    logic       wr_lvl;
    logic       sync_style;
    logic       sync_start;
    logic       go;
    logic       go_read;
    logic       go_local;
    logic       acc_read_r;
    logic       acc_local_r;
    logic       wr_fire;

    always_comb begin
        rd_lvl     = 1'b0;
        wr_lvl     = 1'b0;
        sync_style = 1'b0;
        unique case (type_q)
            STYLE_ASYNC_A: begin
                rd_lvl = !q_r[`HP_SY_RD_WE];
                wr_lvl = !q_r[`HP_SY_WR_RW];
            end
            STYLE_ASYNC_B: begin
                rd_lvl = !q_r[`HP_SY_RD_WE] && q_r[`HP_SY_WR_RW];
                wr_lvl = !q_r[`HP_SY_RD_WE] && !q_r[`HP_SY_WR_RW];
            end
            STYLE_SYNC: begin
                sync_style = 1'b1;
            end
            default: begin
                sync_style = 1'b0;
            end
        endcase
    end

    assign sync_start = sync_style && q_r[`HP_SY_HCLK] && !hclk_prev_r && !q_r[`HP_SY_ALE_TS];
    assign go         = (state_r == ACC_IDLE) && cs_q && (rd_lvl || wr_lvl || sync_start);
    assign go_read    = sync_style ? q_r[`HP_SY_WR_RW] : rd_lvl;
    assign go_local   = select_decode(addr_hi_q)[0];
    assign wr_fire    = go && !go_read && go_local;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hclk_prev_r <= 1'b0;
        end else begin
            hclk_prev_r <= q_r[`HP_SY_HCLK];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r     <= ACC_IDLE;
            acc_read_r  <= 1'b0;
            acc_local_r <= 1'b0;
        end else begin
            unique case (state_r)
                ACC_IDLE: begin
                    if (go) begin
                        state_r     <= ACC_BUSY;
                        acc_read_r  <= go_read;
                        acc_local_r <= go_local;
                    end
                end
                ACC_BUSY: begin
                    if (!cs_q || (!sync_style && !rd_lvl && !wr_lvl)
                        || (sync_style && q_r[`HP_SY_HCLK] && !hclk_prev_r)) begin
                        state_r <= ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Register file
    // -------------------------------------------------------------------------
    logic [13:0] rx_on_r;
    logic [13:0] term_sel_r;
    logic        term_ctrl_r;
    logic [7:0]  read_mux;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rx_on_r     <= `HP_RX_ON_RESET;
            term_sel_r  <= `HP_TERM_RESET;
            term_ctrl_r <= 1'b0;
        end else if (hw_reset_fire) begin
            rx_on_r     <= `HP_RX_ON_RESET;
            term_sel_r  <= `HP_TERM_RESET;
            term_ctrl_r <= 1'b0;
        end else if (wr_fire) begin
            unique case (host_addr[7:0])
                `HP_REG_RX_ON_LO: rx_on_r[7:0]     <= host_data_in;
                `HP_REG_RX_ON_HI: rx_on_r[13:8]    <= host_data_in[5:0];
                `HP_REG_TERM_LO:  term_sel_r[7:0]  <= host_data_in;
                `HP_REG_TERM_HI:  term_sel_r[13:8] <= host_data_in[5:0];
                `HP_REG_GLOBAL:   term_ctrl_r      <= host_data_in[`HP_GLOBAL_TCTL_BIT];
                default:          term_ctrl_r      <= term_ctrl_r;
            endcase
        end
    end

    always_comb begin
        read_mux = 8'h00;
        unique case (host_addr[7:0])
            `HP_REG_RX_ON_LO: read_mux = rx_on_r[7:0];
            `HP_REG_RX_ON_HI: read_mux = {2'h0, rx_on_r[13:8]};
            `HP_REG_TERM_LO:  read_mux = term_sel_r[7:0];
            `HP_REG_TERM_HI:  read_mux = {2'h0, term_sel_r[13:8]};
            `HP_REG_GLOBAL:   read_mux = {7'h00, term_ctrl_r};
            `HP_REG_STATUS:   read_mux = {gate_q, tpin_q, 3'h0, type_q};
            default:          read_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            host_data_out <= 8'h00;
        end else if (go && go_read) begin
            host_data_out <= read_mux;
        end
    end

    assign host_data_oe = (state_r == ACC_BUSY) && acc_read_r && acc_local_r && cs_q;
    assign host_ready   = (state_r == ACC_BUSY) && acc_local_r && cs_q;

    // -------------------------------------------------------------------------
    // Select outputs and receiver control
    // -------------------------------------------------------------------------
    logic [5:0] sel_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sel_r <= 6'h00;
        end else begin
            sel_r <= cs_q ? select_decode(addr_hi_q) : 6'h00;
        end
    end

    assign local_select           = sel_r[0];
    assign expansion_select_out_1 = sel_r[1];
    assign expansion_select_out_2 = sel_r[2];
    assign expansion_select_out_3 = sel_r[3];
    assign expansion_select_out_4 = sel_r[4];
    assign expansion_select_out_5 = sel_r[5];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            receiver_on    <= 14'h0000;
            termination_on <= 14'h0000;
        end else begin
            receiver_on    <= gate_q ? rx_on_r : 14'h0000;
            termination_on <= term_ctrl_r ? {`HP_CHANNELS{tpin_q}} : term_sel_r;
        end
    end

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence read_taken;
        go && go_read && go_local;
    endsequence

    sequence read_driven;
        host_data_oe && (host_data_out == $past(read_mux));
    endsequence

    a_gate_forces_off: assert property (!gate_q |=> receiver_on == 14'h0000)
        else $error("receiver on while power gate low");
    a_gate_follows_reg: assert property (gate_q |=> receiver_on == $past(rx_on_r))
        else $error("receiver power not following channel settings");
    a_term_pin_mode: assert property (term_ctrl_r |=> termination_on == {14{$past(tpin_q)}})
        else $error("termination not following select pin");
    a_term_reg_mode: assert property (!term_ctrl_r |=> termination_on == $past(term_sel_r))
        else $error("termination not following channel settings");
    a_hw_reset_defaults: assert property (hw_reset_fire |=> rx_on_r == 14'h0000 && !term_ctrl_r)
        else $error("hardware reset left settings");
    a_hw_reset_hold: assert property (hw_reset_fire |-> $past(!q_r[`HP_SY_HRST_N], 8))
        else $error("hardware reset taken too early");
    a_decode_reserved: assert property (cs_q && addr_hi_q == 3'h6 |=> sel_r == 6'h00)
        else $error("reserved code drove a select");
    a_decode_all: assert property (cs_q && addr_hi_q == 3'h7 |=> sel_r == 6'h3f)
        else $error("broadcast code missed a select");
    a_decode_one: assert property (cs_q && addr_hi_q inside {[3'h1:3'h5]} |=> $onehot(sel_r) && !sel_r[0])
        else $error("expansion code not one-hot");
    a_idle_when_off: assert property (!cs_q |-> !host_data_oe && !wr_fire && !go)
        else $error("bus answered without chip select");
    a_read_drives: assert property (read_taken ##1 cs_q |-> read_driven)
        else $error("read data not driven");

endmodule

//--- verilog/host_port_map.svh
/*
 * Constants of the parallel host port: register offsets, reset values,
 * synchroniser bit positions and the hardware reset hold time.
 * Assumes inclusion by the package and the host port module only.
 */
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define HP_REG_RX_ON_LO    8'h00
`define HP_REG_RX_ON_HI    8'h01
`define HP_REG_TERM_LO     8'h02
`define HP_REG_TERM_HI     8'h03
`define HP_REG_GLOBAL      8'h04
`define HP_REG_STATUS      8'h05
`define HP_GLOBAL_TCTL_BIT 0
`define HP_CHANNELS        14
`define HP_RX_ON_RESET     14'h0000
`define HP_TERM_RESET      14'h0000

// -----------------------------------------------------------------------------
// Synchroniser bit positions and idle levels
// -----------------------------------------------------------------------------
`define HP_SY_CS_N         0
`define HP_SY_ALE_TS       1
`define HP_SY_WR_RW        2
`define HP_SY_RD_WE        3
`define HP_SY_HCLK         4
`define HP_SY_HRST_N       5
`define HP_SY_GATE         6
`define HP_SY_TPIN         7
`define HP_SY_TYPE_LSB     8
`define HP_SY_ADDR_LSB     11
`define HP_SYNC_W          14
`define HP_SYNC_IDLE       14'h002f

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define HP_CLK_PERIOD_NS   10
`define HP_RESET_TIME_NS   10000
`define HP_RESET_CYCLES    ((`HP_RESET_TIME_NS + `HP_CLK_PERIOD_NS - 1) / `HP_CLK_PERIOD_NS)

`endif

//--- verilog/host_port_pkg.sv
/*
 * Types of the parallel host port: bus styles and access states.
 * Assumes host_port_map.svh on the include path.
 */
`include "host_port_map.svh"

package host_port_pkg;

    typedef enum logic [2:0] {
        STYLE_ASYNC_A = 3'h0,
        STYLE_ASYNC_B = 3'h1,
        STYLE_SYNC    = 3'h7
    } host_style_t;

    typedef enum logic {
        ACC_IDLE = 1'b0,
        ACC_BUSY = 1'b1
    } acc_state_t;

endpackage

//--- verification/host_model.sv
/*
 * Host processor model on the parallel bus, both asynchronous styles.
 * Assumes one system clock shared with the device and a bench calling its tasks.
 */
`timescale 1ns/100ps

module host_model (
    input  wire logic        clk_sys,
    input  wire logic        host_ready,
    input  wire logic        host_data_oe,
    input  wire logic [7:0]  host_data_out,
    output logic             host_reset_n,
    output logic [2:0]       host_type_select,
    output logic             host_cs_n,
    output logic             host_ale_ts,
    output logic             host_wr_rw,
    output logic             host_rd_we,
    output logic             host_bus_clk,
    output logic [10:0]      host_addr,
    output logic [7:0]       host_data_in
);
    // -------------------------------------------------------------------------
    // Static strap and idle pins
    // -------------------------------------------------------------------------
    initial begin
        host_type_select = 3'h0;
        host_reset_n = 1'b1;
        host_cs_n = 1'b1;
        host_ale_ts = 1'b1;
        host_wr_rw = 1'b1;
        host_rd_we = 1'b1;
        host_bus_clk = 1'b0;
        host_addr = 11'h000;
        host_data_in = 8'h00;
    end

    // -------------------------------------------------------------------------
    // Bus cycles
    // -------------------------------------------------------------------------
    task automatic access(input logic [10:0] a, input logic wr, input logic [7:0] d,
                          output logic [7:0] q, output logic oe, output logic ok);
        int n;
        ok = 1'b0;
        oe = 1'b0;
        q = 8'h00;
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_addr <= a;
        host_data_in <= d;
        if (host_type_select == 3'h1) begin
            host_rd_we <= 1'b0;
            host_wr_rw <= !wr;
        end else if (wr) begin
            host_wr_rw <= 1'b0;
        end else begin
            host_rd_we <= 1'b0;
        end
        for (n = 0; n < 12 && !ok; n++) begin
            @(posedge clk_sys);
            #1;
            ok = (host_ready === 1'b1);
        end
        q = host_data_out;
        oe = host_data_oe;
        @(posedge clk_sys);
        host_cs_n <= 1'b1;
        host_wr_rw <= 1'b1;
        host_rd_we <= 1'b1;
        host_addr <= ~a;
        host_data_in <= ~d;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic select_on(input logic [10:0] a);
        @(posedge clk_sys);
        host_cs_n <= 1'b0;
        host_addr <= a;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    task automatic select_off();
        @(posedge clk_sys);
        host_cs_n <= 1'b1;
        host_addr <= ~host_addr;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic reset_pulse(input int cycles);
        @(posedge clk_sys);
        host_reset_n <= 1'b0;
        repeat (cycles) @(posedge clk_sys);
        host_reset_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    task automatic set_style(input logic [2:0] s);
        host_type_select <= s;
    endtask
endmodule

//--- verification/tb.sv
/*
 * Self-checking bench of the host port with select decoder and receiver control.
 * Assumes the host model drives every host pin; the bench drives the global pins.
 */
`timescale 1ns/100ps

module tb;
    logic        clk_sys, resetn, receiver_power_gate, receive_termination_pin;
    logic        host_reset_n, host_cs_n, host_ale_ts, host_wr_rw, host_rd_we, host_bus_clk;
    logic [2:0]  host_type_select;
    logic [10:0] host_addr;
    logic [7:0]  host_data_in, host_data_out;
    logic        host_data_oe, host_ready, local_select;
    logic [5:1]  xs;
    logic [13:0] receiver_on, termination_on;
    int          error_cnt, check_count;

    host_port_select_and_rx_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .host_reset_n(host_reset_n),
        .host_type_select(host_type_select), .host_cs_n(host_cs_n), .host_ale_ts(host_ale_ts),
        .host_wr_rw(host_wr_rw), .host_rd_we(host_rd_we), .host_bus_clk(host_bus_clk),
        .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .host_ready(host_ready), .local_select(local_select),
        .expansion_select_out_1(xs[1]), .expansion_select_out_2(xs[2]), .expansion_select_out_3(xs[3]),
        .expansion_select_out_4(xs[4]), .expansion_select_out_5(xs[5]),
        .receiver_power_gate(receiver_power_gate), .receive_termination_pin(receive_termination_pin),
        .receiver_on(receiver_on), .termination_on(termination_on));

    host_model hm (.clk_sys(clk_sys), .host_ready(host_ready), .host_data_oe(host_data_oe),
        .host_data_out(host_data_out), .host_reset_n(host_reset_n), .host_type_select(host_type_select),
        .host_cs_n(host_cs_n), .host_ale_ts(host_ale_ts), .host_wr_rw(host_wr_rw), .host_rd_we(host_rd_we),
        .host_bus_clk(host_bus_clk), .host_addr(host_addr), .host_data_in(host_data_in));

    // -------------------------------------------------------------------------
    // Clock, compare and bus helpers
    // -------------------------------------------------------------------------
    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    task automatic give_verdict();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask

    task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic rdy);
        logic [7:0] q;
        logic       oe, ok;
        hm.access(a, 1'b1, d, q, oe, ok);
        chk("write ready", {13'h0, rdy}, {13'h0, ok});
        if (ok !== rdy) give_verdict();
    endtask

    task automatic rd(input logic [10:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic       oe, ok;
        hm.access(a, 1'b0, 8'h00, q, oe, ok);
        chk("read ready", 14'h0001, {13'h0, ok});
        if (ok !== 1'b1) give_verdict();
        chk("read oe", 14'h0001, {13'h0, oe});
        chk("read data", {6'h00, e}, {6'h00, q});
    endtask

    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #1;
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_defaults();
        chk("rx after reset", 14'h0000, receiver_on);
        chk("term after reset", 14'h0000, termination_on);
        chk("selects idle", 14'h0000, {8'h00, xs, local_select});
    endtask

    task automatic t_rx_power();
        @(posedge clk_sys);
        receiver_power_gate <= 1'b1;
        wr(11'h000, 8'ha5, 1'b1);
        wr(11'h001, 8'h3f, 1'b1);
        settle();
        chk("rx gate high", 14'h3fa5, receiver_on);
        rd(11'h000, 8'ha5);
        rd(11'h001, 8'h3f);
        rd(11'h010, 8'h00);
        receiver_power_gate <= 1'b0;
        settle();
        chk("rx gate low", 14'h0000, receiver_on);
        @(posedge clk_sys);
        receiver_power_gate <= 1'b1;
        settle();
    endtask

    task automatic t_remote_write();
        wr(11'h100, 8'h00, 1'b0);
        chk("rx remote write", 14'h3fa5, receiver_on);
    endtask

    task automatic t_termination();
        wr(11'h002, 8'h5a, 1'b1);
        wr(11'h003, 8'h12, 1'b1);
        settle();
        chk("term from regs", 14'h125a, termination_on);
        wr(11'h004, 8'h01, 1'b1);
        receive_termination_pin <= 1'b1;
        settle();
        chk("term pin high", 14'h3fff, termination_on);
        @(posedge clk_sys);
        receive_termination_pin <= 1'b0;
        settle();
        chk("term pin low", 14'h0000, termination_on);
        wr(11'h004, 8'h00, 1'b1);
        settle();
        chk("term back to regs", 14'h125a, termination_on);
    endtask

    task automatic t_decoder();
        logic [5:0] e;
        for (int c = 0; c < 8; c++) begin
            e = (c == 7) ? 6'h3f : (c == 6) ? 6'h00 : 6'h01 << c;
            hm.select_on({c[2:0], 8'h00});
            chk("select code", {8'h00, e}, {8'h00, xs, local_select});
            hm.select_off();
            chk("select released", 14'h0000, {8'h00, xs, local_select});
        end
    endtask

    task automatic t_hw_reset();
        hm.reset_pulse(500);
        chk("rx short reset", 14'h3fa5, receiver_on);
        hm.reset_pulse(1010);
        chk("rx long reset", 14'h0000, receiver_on);
        chk("term long reset", 14'h0000, termination_on);
        rd(11'h002, 8'h00);
    endtask

    task automatic t_style_b();
        wr(11'h000, 8'h11, 1'b1);
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        hm.set_style(3'h1);
        resetn <= 1'b1;
        settle();
        chk("rx second reset", 14'h0000, receiver_on);
        wr(11'h002, 8'h3c, 1'b1);
        rd(11'h002, 8'h3c);
        rd(11'h005, 8'h81);
    endtask

    // -------------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------------
    initial begin
        error_cnt = 0;
        check_count = 0;
        resetn = 1'b0;
        receiver_power_gate = 1'b0;
        receive_termination_pin = 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        settle();
        t_defaults();
        t_rx_power();
        t_remote_write();
        t_termination();
        t_decoder();
        t_hw_reset();
        t_style_b();
        give_verdict();
    end
endmodule
